/* hw/ics_map.svh */
/*
  constants for the capture sequencer: field resets, ranges, tick counts.
  assumes a 50 MHz system clock.
*/
`ifndef ICS_MAP_SVH
`define ICS_MAP_SVH
`define ICS_CLK_HZ 50000000
`define ICS_TICK_US 32
`define ICS_TICK_CYC ((`ICS_CLK_HZ / 1000000) * `ICS_TICK_US)
`define ICS_MS_US 1000
`define ICS_MS_TICK_CYC ((`ICS_CLK_HZ / 1000000) * `ICS_MS_US)
`define ICS_CONT_CNT_RST 8'h02
`define ICS_RC_LIMIT_RST 8'h0A
`define ICS_RC_LIMIT_MIN 8'h03
`define ICS_HIST_RST 8'h0A
`define ICS_RAPID_CNT_RST 8'h01
`define ICS_RAPID_MAX 8'h20
`define ICS_CONT_SLOT_SUB 8'h03
`define ICS_TMO_RST 16'h1388
`define ICS_GOOD_RST 8'h01
`define ICS_NUM_GAPS 8
`define ICS_SLOTS 64
`endif

/* hw/ics_pkg.sv */
/*
  types for the capture sequencer.
  no surroundings assumed.
*/
package ics_pkg;
  typedef enum logic [4:0] {
    ICS_IDLE = 5'h01,
    ICS_WAIT = 5'h02,
    ICS_CAPT = 5'h04,
    ICS_PROC = 5'h08,
    ICS_DONE = 5'h10
  } ics_state_t;
endpackage

/* hw/ics_sequencer.sv */
/*
  capture sequencer: trigger delay, gap delays, capture limits, per-image
  processing timeout, no-read retention and good-decode counting.
  assumes config strobes, trigger and decode events synchronous to clk_i.
*/
`timescale 1ns/100ps
`include "ics_map.svh"

// Functional notes
// - continuous count 1..255, default 2
// - read cycle image limit 3..255, default 10
// - history depth 0..255, default 10
// - delays only used in rapid mode
// - trigger to first capture delay
// - per-gap delay, zero is back-to-back
// - eighth gap reused beyond eight
// - omitted fields keep old values
// - processing timeout 1..65535 ms, aborts
// - timeout in both capture modes
// - timeout starts after capture ends
// - timeout without decode is no-read
// - slots: rapid count, continuous minus three (code takes rapid_cnt minus three in continuous mode, not the continuous count)
// - storage type 0 clears, 1 stores
// - store last processed image on no-read exit
// - reinit storage on reset, mode, test
// - first-fill mode discards when full
// - overwrite mode replaces oldest image
// - good read after threshold decodes
// - rapid mode up to 32 captures
module ics_sequencer (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic trigger_i,
  input wire logic cfg_mode_we_i,
  input wire logic cfg_mode_i,
  input wire logic cfg_rapid_cnt_we_i,
  input wire logic [7:0] cfg_rapid_cnt_i,
  input wire logic cfg_cont_cnt_we_i,
  input wire logic [7:0] cfg_cont_cnt_i,
  input wire logic cfg_limit_we_i,
  input wire logic [7:0] cfg_limit_i,
  input wire logic cfg_hist_we_i,
  input wire logic [7:0] cfg_hist_i,
  input wire logic [8:0] cfg_delay_we_i,
  input wire logic [15:0] cfg_delay_i,
  input wire logic cfg_tmo_we_i,
  input wire logic [15:0] cfg_tmo_i,
  input wire logic cfg_store_we_i,
  input wire logic cfg_store_type_i,
  input wire logic cfg_store_mode_i,
  input wire logic cfg_good_we_i,
  input wire logic [7:0] cfg_good_i,
  input wire logic test_mode_i,
  input wire logic save_reset_i,
  input wire logic capture_done_i,
  input wire logic decode_ok_i,
  output logic capture_o,
  output logic abort_o,
  output logic no_read_o,
  output logic good_read_o,
  output logic busy_o,
  output logic [7:0] capt_index_o,
  output logic [7:0] history_depth_o,
  output logic [7:0] stored_count_o,
  output logic [7:0] stored_image_o
);
  logic cont_mode;
  logic [7:0] rapid_cnt;
  logic [7:0] cont_cnt;
  logic [7:0] limit;
  logic [7:0] hist;
  logic [15:0] delay [9];
  logic [15:0] tmo;
  logic store_en;
  logic store_mode;
  logic [7:0] good_need;
  ics_pkg::ics_state_t state;
  ics_pkg::ics_state_t next_state;
  logic [15:0] dcnt;
  logic [15:0] next_dcnt;
  logic [7:0] done_cnt;
  logic [7:0] next_done_cnt;
  logic [7:0] good_cnt;
  logic [7:0] next_good_cnt;
  logic [7:0] last_img;
  logic [7:0] next_last_img;
  logic any_good;
  logic next_any_good;
  logic capture;
  logic abort;
  logic no_read;
  logic good_read;
  logic store_pulse;
  logic tick32;
  logic tick_ms;
  logic tick_clr;
  logic store_init;
  logic [7:0] slots;
  logic [7:0] target;
  logic test_q;

  // saturating 8-bit range clamp
  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // gap delay for capture n (0-based next capture)
  function automatic logic [3:0] gap_idx(input logic [7:0] n);
    gap_idx = (n >= 8'(`ICS_NUM_GAPS)) ? 4'(`ICS_NUM_GAPS) : n[3:0];
  endfunction

  ics_ticker #(.CYC(`ICS_TICK_CYC)) u_tick32 (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clr_i(tick_clr),
    .tick_o(tick32)
  );
  ics_ticker #(.CYC(`ICS_MS_TICK_CYC)) u_tickms (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clr_i(tick_clr),
    .tick_o(tick_ms)
  );

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cont_mode <= 1'b1;
      rapid_cnt <= `ICS_RAPID_CNT_RST;
      cont_cnt <= `ICS_CONT_CNT_RST;
      limit <= `ICS_RC_LIMIT_RST;
      hist <= `ICS_HIST_RST;
      tmo <= `ICS_TMO_RST;
      store_en <= 1'b0;
      store_mode <= 1'b0;
      good_need <= `ICS_GOOD_RST;
      test_q <= 1'b0;
      for (int i = 0; i < 9; i++)
      begin
        delay[i] <= 16'h0000;
      end
    end
    else
    begin
      test_q <= test_mode_i;
      if (cfg_mode_we_i)
      begin
        cont_mode <= cfg_mode_i;
      end
      if (cfg_rapid_cnt_we_i)
      begin
        rapid_cnt <= clamp8(cfg_rapid_cnt_i, 8'h01, `ICS_RAPID_MAX);
      end
      if (cfg_cont_cnt_we_i)
      begin
        cont_cnt <= clamp8(cfg_cont_cnt_i, 8'h01, 8'hFF);
      end
      if (cfg_limit_we_i)
      begin
        limit <= clamp8(cfg_limit_i, `ICS_RC_LIMIT_MIN, 8'hFF);
      end
      if (cfg_hist_we_i)
      begin
        hist <= cfg_hist_i;
      end
      if (cfg_tmo_we_i)
      begin
        tmo <= (cfg_tmo_i == 16'h0000) ? 16'h0001 : cfg_tmo_i;
      end
      if (cfg_store_we_i)
      begin
        store_en <= cfg_store_type_i;
        store_mode <= cfg_store_mode_i;
      end
      if (cfg_good_we_i)
      begin
        good_need <= clamp8(cfg_good_i, 8'h01, 8'hFF);
      end
      for (int i = 0; i < 9; i++)
      begin
        if (cfg_delay_we_i[i])
        begin
          delay[i] <= cfg_delay_i;
        end
      end
    end
  end

  // captures per cycle: mode count bounded by limit
  always_comb
  begin
    target = cont_mode ? cont_cnt : rapid_cnt;
    if (target > limit)
    begin
      target = limit;
    end
  end

  // sequence next-state
  always_comb
  begin
    next_state = state;
    next_dcnt = dcnt;
    next_done_cnt = done_cnt;
    next_good_cnt = good_cnt;
    next_last_img = last_img;
    next_any_good = any_good;
    capture = 1'b0;
    abort = 1'b0;
    no_read = 1'b0;
    good_read = 1'b0;
    store_pulse = 1'b0;
    tick_clr = 1'b0;
    unique case (state)
      ics_pkg::ICS_IDLE:
      begin
        tick_clr = 1'b1;
        if (trigger_i)
        begin
          next_done_cnt = 8'h00;
          next_any_good = 1'b0;
          // first delay only in rapid mode
          next_dcnt = cont_mode ? 16'h0000 : delay[0];
          next_state = ics_pkg::ICS_WAIT;
        end
      end
      ics_pkg::ICS_WAIT:
      begin
        if (dcnt == 16'h0000)
        begin
          capture = 1'b1;
          next_state = ics_pkg::ICS_CAPT;
        end
        else if (tick32)
        begin
          next_dcnt = dcnt - 16'h0001;
        end
      end
      ics_pkg::ICS_CAPT:
      begin
        tick_clr = 1'b1;
        if (capture_done_i)
        begin
          next_dcnt = tmo;
          next_good_cnt = 8'h00;
          next_state = ics_pkg::ICS_PROC;
        end
      end
      ics_pkg::ICS_PROC:
      begin
        if (decode_ok_i)
        begin
          next_good_cnt = good_cnt + 8'h01;
        end
        if (decode_ok_i && good_cnt + 8'h01 >= good_need)
        begin
          good_read = 1'b1;
          next_any_good = 1'b1;
          next_last_img = done_cnt;
          next_done_cnt = done_cnt + 8'h01;
          next_state = ics_pkg::ICS_DONE;
        end
        // abort on expiry in any mode
        else if (tick_ms && dcnt == 16'h0001)
        begin
          abort = 1'b1;
          no_read = (good_cnt == 8'h00) && !decode_ok_i;
          next_last_img = done_cnt;
          next_done_cnt = done_cnt + 8'h01;
          next_state = ics_pkg::ICS_DONE;
        end
        else if (tick_ms)
        begin
          next_dcnt = dcnt - 16'h0001;
        end
      end
      ics_pkg::ICS_DONE:
      begin
        tick_clr = 1'b1;
        if (done_cnt >= target)
        begin
          // keep last processed image on no-read exit
          store_pulse = store_en && !any_good;
          next_state = ics_pkg::ICS_IDLE;
        end
        else
        begin
          // gaps beyond eight reuse the eighth
          next_dcnt = cont_mode ? 16'h0000 : delay[gap_idx(done_cnt)];
          next_state = ics_pkg::ICS_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state <= ics_pkg::ICS_IDLE;
      dcnt <= 16'h0000;
      done_cnt <= 8'h00;
      good_cnt <= 8'h00;
      last_img <= 8'h00;
      any_good <= 1'b0;
      capture_o <= 1'b0;
      abort_o <= 1'b0;
      no_read_o <= 1'b0;
      good_read_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      dcnt <= next_dcnt;
      done_cnt <= next_done_cnt;
      good_cnt <= next_good_cnt;
      last_img <= next_last_img;
      any_good <= next_any_good;
      capture_o <= capture;
      abort_o <= abort;
      no_read_o <= no_read;
      good_read_o <= good_read;
    end
  end

  assign slots = cont_mode ?
    ((rapid_cnt > `ICS_CONT_SLOT_SUB) ? rapid_cnt - `ICS_CONT_SLOT_SUB
                                      : 8'h00) : rapid_cnt;
  // clear on type 0, reset-save, mode change or test entry
  assign store_init = (cfg_store_we_i && !cfg_store_type_i) || save_reset_i
    || (cfg_mode_we_i && cfg_mode_i != cont_mode)
    || (test_mode_i && !test_q);

  ics_store u_store (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .init_i(store_init),
    .store_i(store_pulse),
    .overwrite_i(store_mode),
    .slots_i(slots),
    .image_i(last_img),
    .count_o(stored_count_o),
    .newest_o(stored_image_o)
  );

  assign busy_o = state != ics_pkg::ICS_IDLE;
  assign capt_index_o = done_cnt;
  assign history_depth_o = hist;

  // never more captures than the limit
  property p_limit;
    @(posedge clk_i) disable iff (srst_i)
      capture_o |-> done_cnt < limit;
  endproperty
  a_limit: assert property (p_limit) else $error("capture over limit");

  property p_cont_nodelay;
    @(posedge clk_i) disable iff (srst_i)
      (state == ics_pkg::ICS_IDLE && trigger_i && cont_mode)
        |=> ##1 capture_o;
  endproperty
  a_cont_nodelay: assert property (p_cont_nodelay)
    else $error("delay used in continuous mode");

  property p_zero_gap;
    @(posedge clk_i) disable iff (srst_i)
      (state == ics_pkg::ICS_WAIT && dcnt == 16'h0000) |=> capture_o;
  endproperty
  a_zero_gap: assert property (p_zero_gap)
    else $error("zero delay not back to back");

  property p_no_early;
    @(posedge clk_i) disable iff (srst_i)
      (state == ics_pkg::ICS_WAIT && dcnt != 16'h0000) |=> !capture_o;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("capture before delay ran out");

  property p_tmo_arm;
    @(posedge clk_i) disable iff (srst_i)
      (state == ics_pkg::ICS_CAPT && capture_done_i) |=> dcnt == tmo;
  endproperty
  a_tmo_arm: assert property (p_tmo_arm)
    else $error("timeout not armed at capture end");

  property p_noread;
    @(posedge clk_i) disable iff (srst_i)
      no_read_o |-> abort_o && good_cnt == 8'h00;
  endproperty
  a_noread: assert property (p_noread)
    else $error("no-read without abort");

  property p_good;
    @(posedge clk_i) disable iff (srst_i)
      good_read_o |-> $past(good_cnt) + 8'h01 >= good_need;
  endproperty
  a_good: assert property (p_good)
    else $error("good read below threshold");

  property p_slots;
    @(posedge clk_i) disable iff (srst_i)
      stored_count_o <= slots || $past(cfg_rapid_cnt_we_i)
        || $past(cfg_mode_we_i);
  endproperty
  a_slots: assert property (p_slots)
    else $error("storage over slot count");

  property p_clear;
    @(posedge clk_i) disable iff (srst_i)
      save_reset_i |=> stored_count_o == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("storage not reinitialised");
endmodule // ics_sequencer

/* hw/ics_store.sv */
/*
  no-read image slot bookkeeping: first-fill or overwrite-oldest.
  assumes the sequencer presents one store pulse per read cycle.
*/
`timescale 1ns/100ps
`include "ics_map.svh"
module ics_store (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic init_i,
  input wire logic store_i,
  input wire logic overwrite_i,
  input wire logic [7:0] slots_i,
  input wire logic [7:0] image_i,
  output logic [7:0] count_o,
  output logic [7:0] newest_o
);
  logic [7:0] mem [`ICS_SLOTS];
  logic [7:0] wptr;
  logic [7:0] cnt;
  logic [7:0] next_wptr;
  logic [7:0] next_cnt;
  logic do_wr;

  // pointer and fill level
  always_comb
  begin
    next_wptr = wptr;
    next_cnt = cnt;
    do_wr = 1'b0;
    if (init_i)
    begin
      next_wptr = 8'h00;
      next_cnt = 8'h00;
    end
    else if (cnt > slots_i || wptr >= slots_i)
    begin
      // slot count shrank: trim fill level, restart pointer
      next_cnt = (cnt > slots_i) ? slots_i : cnt;
      next_wptr = 8'h00;
    end
    else if (store_i && slots_i != 8'h00)
    begin
      if (cnt < slots_i)
      begin
        do_wr = 1'b1;
        next_cnt = cnt + 8'h01;
      end
      else if (overwrite_i)
      begin
        do_wr = 1'b1;
      end
      if (do_wr)
      begin
        next_wptr = (wptr + 8'h01 >= slots_i) ? 8'h00 : wptr + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wptr <= 8'h00;
      cnt <= 8'h00;
      newest_o <= 8'h00;
    end
    else
    begin
      wptr <= next_wptr;
      cnt <= next_cnt;
      if (do_wr)
      begin
        mem[wptr[5:0]] <= image_i;
        newest_o <= image_i;
      end
    end
  end

  assign count_o = cnt;
endmodule // ics_store

/* hw/ics_ticker.sv */
/*
  tick divider: one-cycle enable every CYC clocks.
  assumes single clock, synchronous reset.
*/
`timescale 1ns/100ps
module ics_ticker #(
  parameter int CYC = 1600
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic clr_i,
  output logic tick_o
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  // free-running count, restarted by clr_i
  always_comb
  begin
    next_cnt = cnt + 16'h0001;
    if (clr_i || cnt == 16'(CYC - 1))
    begin
      next_cnt = 16'h0000;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt <= 16'h0000;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end

  assign tick_o = !clr_i && cnt == 16'(CYC - 1);
endmodule // ics_ticker

/* sim/ics_camera_model.sv */
/*
  camera model: answers capture requests with done and decode pulses.
  assumes capture_i is a one-cycle registered pulse on clk_i.
*/
`timescale 1ns/100ps
module ics_camera_model (
  input wire logic clk_i,
  input wire logic capture_i,
  input wire logic [7:0] lat_i,
  input wire logic [7:0] decodes_i,
  output logic done_o,
  output logic decode_o
);
  // one answer per capture
  // done after lat_i cycles, then decodes_i decode pulses
  initial
  begin
    done_o = 1'b0;
    decode_o = 1'b0;
    forever
    begin
      @(negedge clk_i);
      if (capture_i === 1'b1)
      begin
        repeat (lat_i) @(negedge clk_i);
        done_o = 1'b1;
        @(negedge clk_i);
        done_o = 1'b0;
        repeat (decodes_i)
        begin
          repeat (2) @(negedge clk_i);
          decode_o = 1'b1;
          @(negedge clk_i);
          decode_o = 1'b0;
        end
      end
    end
  end
endmodule // ics_camera_model

/* sim/test_ics_sequencer.sv */
/*
  bench for the capture sequencer: queue scoreboard of read results.
  assumes the camera model in ics_camera_model.sv.
*/
`timescale 1ns/100ps
module test_ics_sequencer;
  logic clk_i = 1'b0, srst_i = 1'b1, trigger_i = 1'b0;
  logic cfg_mode_we_i = 1'b0, cfg_mode_i = 1'b1;
  logic cfg_rapid_cnt_we_i = 1'b0, cfg_cont_cnt_we_i = 1'b0;
  logic cfg_limit_we_i = 1'b0, cfg_hist_we_i = 1'b0, cfg_tmo_we_i = 1'b0;
  logic cfg_store_we_i = 1'b0, cfg_store_type_i = 1'b0;
  logic cfg_store_mode_i = 1'b0, cfg_good_we_i = 1'b0;
  logic test_mode_i = 1'b0, save_reset_i = 1'b0;
  logic [7:0] cfg_rapid_cnt_i = 8'h01, cfg_cont_cnt_i = 8'h02;
  logic [7:0] cfg_limit_i = 8'h0A, cfg_hist_i = 8'h0A, cfg_good_i = 8'h01;
  logic [8:0] cfg_delay_we_i = 9'h000;
  logic [15:0] cfg_delay_i = 16'h0000, cfg_tmo_i = 16'h1388;
  logic capture_done_i, decode_ok_i, capture_o, abort_o, no_read_o;
  logic good_read_o, busy_o;
  logic [7:0] capt_index_o, history_depth_o, stored_count_o, stored_image_o;
  logic [7:0] lat = 8'h01, decodes = 8'h01;
  byte exp_q[$];
  int errors = 0, samples_checked = 0, ncap, first, last, nab;

  ics_sequencer uut (
    .clk_i, .srst_i, .trigger_i, .cfg_mode_we_i, .cfg_mode_i,
    .cfg_rapid_cnt_we_i, .cfg_rapid_cnt_i, .cfg_cont_cnt_we_i,
    .cfg_cont_cnt_i, .cfg_limit_we_i, .cfg_limit_i, .cfg_hist_we_i,
    .cfg_hist_i, .cfg_delay_we_i, .cfg_delay_i, .cfg_tmo_we_i, .cfg_tmo_i,
    .cfg_store_we_i, .cfg_store_type_i, .cfg_store_mode_i, .cfg_good_we_i,
    .cfg_good_i, .test_mode_i, .save_reset_i, .capture_done_i,
    .decode_ok_i, .capture_o, .abort_o, .no_read_o, .good_read_o, .busy_o,
    .capt_index_o, .history_depth_o, .stored_count_o, .stored_image_o
  );

  ics_camera_model cam (
    .clk_i(clk_i),
    .capture_i(capture_o),
    .lat_i(lat),
    .decodes_i(decodes),
    .done_o(capture_done_i),
    .decode_o(decode_ok_i)
  );

  // clock
  always #10 clk_i = ~clk_i;

  // end of run: counts then verdict
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // compare one value
  task check(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // drop strobes, then hand back at a fresh falling edge
  task step;
    @(negedge clk_i);
    {cfg_mode_we_i, cfg_rapid_cnt_we_i, cfg_cont_cnt_we_i} = 3'h0;
    {cfg_limit_we_i, cfg_hist_we_i, cfg_tmo_we_i} = 3'h0;
    {cfg_store_we_i, cfg_good_we_i, save_reset_i} = 3'h0;
    cfg_delay_we_i = 9'h000;
    @(negedge clk_i);
  endtask

  // one read cycle: trigger, count captures and aborts until idle
  task run;
    int n;
    n = 0;
    ncap = 0;
    first = 0;
    nab = 0;
    trigger_i = 1'b1;
    do
    begin
      @(negedge clk_i);
      trigger_i = 1'b0;
      n++;
      if (capture_o === 1'b1)
      begin
        ncap++;
        last = n;
        if (first == 0)
          first = n;
      end
      if (abort_o === 1'b1)
        nab++;
    end
    while ((busy_o !== 1'b0 || n < 3) && n < 60000);
    check(busy_o, 1'b0, "cycle did not end");
    check(exp_q.size(), 0, "results missing");
  endtask

  // scoreboard: oldest note against each read result
  always @(negedge clk_i)
    if (good_read_o === 1'b1 || no_read_o === 1'b1)
    begin
      samples_checked++;
      if (exp_q.size() == 0 || exp_q.pop_front() != (good_read_o ? "G" : "N"))
      begin
        errors++;
        $display("ERROR %0t unexpected read result", $time);
      end
    end

  // watchdog
  initial
  begin
    repeat (80000) @(posedge clk_i);
    errors++;
    $display("ERROR %0t run hung", $time);
    give_verdict;
  end

  // tests
  initial
  begin
    void'($urandom(42));
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    step;
    check(history_depth_o, 8'h0A, "history reset");
    check(stored_count_o, 8'h00, "storage reset");
    $display("test defaults done");
    // continuous: delays set but ignored, two decodes needed
    cfg_delay_we_i = 9'h1FF;
    cfg_delay_i = 16'h0005;
    cfg_good_we_i = 1'b1;
    cfg_good_i = 8'h02;
    lat = 8'($urandom_range(4, 1));
    decodes = 8'h02;
    step;
    repeat (2) exp_q.push_back("G");
    run;
    check(ncap, 2, "continuous count");
    check(first, 2, "no delay in continuous");
    check(capt_index_o, 8'h02, "images done");
    $display("test continuous done");
    // limit below range clamps to three
    cfg_cont_cnt_we_i = 1'b1;
    cfg_cont_cnt_i = 8'h05;
    cfg_limit_we_i = 1'b1;
    cfg_limit_i = 8'h01;
    lat = 8'($urandom_range(4, 1));
    step;
    repeat (3) exp_q.push_back("G");
    run;
    check(ncap, 3, "per cycle limit");
    $display("test limit done");
    // rapid: first delay two ticks, later gap write leaves it alone
    cfg_mode_we_i = 1'b1;
    cfg_mode_i = 1'b0;
    cfg_rapid_cnt_we_i = 1'b1;
    cfg_rapid_cnt_i = 8'h03;
    cfg_delay_we_i = 9'h001;
    cfg_delay_i = 16'h0002;
    cfg_good_we_i = 1'b1;
    cfg_good_i = 8'h01;
    decodes = 8'h01;
    step;
    cfg_delay_we_i = 9'h1FE;
    cfg_delay_i = 16'h0000;
    step;
    repeat (3) exp_q.push_back("G");
    run;
    check(ncap, 3, "rapid count");
    check(first, 2 * 1600 + 2, "first delay");
    $display("test rapid done");
    // rapid ten: only the eighth gap is one tick, so it runs twice
    cfg_rapid_cnt_we_i = 1'b1;
    cfg_rapid_cnt_i = 8'h0A;
    cfg_limit_we_i = 1'b1;
    cfg_limit_i = 8'h0A;
    cfg_delay_we_i = 9'h001;
    cfg_delay_i = 16'h0000;
    step;
    cfg_delay_we_i = 9'h100;
    cfg_delay_i = 16'h0001;
    step;
    repeat (10) exp_q.push_back("G");
    run;
    check(ncap, 10, "rapid ten");
    check(capt_index_o, 8'h0A, "images done");
    check((last - first) / 1600, 2, "eighth gap reused");
    $display("test gap reuse done");
    // timeout with no decode, stored on exit
    cfg_tmo_we_i = 1'b1;
    cfg_tmo_i = 16'h0000;
    cfg_store_we_i = 1'b1;
    cfg_store_type_i = 1'b1;
    cfg_rapid_cnt_we_i = 1'b1;
    cfg_rapid_cnt_i = 8'h01;
    cfg_hist_we_i = 1'b1;
    cfg_hist_i = 8'($urandom_range(255, 0));
    decodes = 8'h00;
    step;
    check(history_depth_o, cfg_hist_i, "history depth");
    exp_q.push_back("N");
    run;
    check(nab, 1, "processing abort");
    check(stored_count_o, 8'h01, "no-read stored");
    check(stored_image_o, 8'h00, "stored image index");
    cfg_mode_we_i = 1'b1;
    cfg_mode_i = 1'b1;
    step;
    check(stored_count_o, 8'h00, "mode change clears");
    save_reset_i = 1'b1;
    step;
    check(stored_count_o, 8'h00, "reset-save clears");
    $display("test timeout done");
    give_verdict;
  end
endmodule // test_ics_sequencer
